/* File: erw_top.v */
// Contract
// - Tagging: 0 never; 1 skips VID 0 and port_vlan_id; 2 skips VID 0; 3 always.
// - TPID select 0 gives 0x8100, 1 gives 0x88A8, 2 the port custom TPID.
// - TPID select 3 uses custom TPID unless frame arrived C-tagged, then 0x8100.
// - Priority source 0 classified, 1 reserved, 2 port values, 3 class map.
// - Eight class entries per port give PCP and DEI, indexed by QoS class.
// - Port holds custom TPID, DEI, PCP and VID; VID resets to 1, rest zero.
// - Header insert enable puts the internal frame header into each outgoing frame.
// - Header position 0 places it before destination MAC, 1 after source MAC.
// - Network frames: CRC mode 0 on change, 1 never, 2 always recompute.
// - Injected frames recompute CRC when enable set, never when clear; resets set.
// - Discard all enable drops every frame bound for that egress port.
// - Ageing disable stops frame ageing on that port; software sets it on half-duplex.
// - Codepoint mode 0 keeps DSCP, 1 analyzer DSCP, 2 analyzer DSCP remapped.
// - 64 entries by frame DSCP give QoS class when port enables codepoint class.
// - A DSCP feeds classification only when its entry is trusted.
// - With translation enabled on ingress port, DSCP becomes the entry's translation.
// - Each codepoint entry has a rewrite select bit marking it rewritable.
// - Eight class entries give a DSCP; rewrite by class uses the frame's class.
// - 28 per-port register groups 0x80 apart, then one common group.
// - Shared 64-entry table remaps each DSCP to a replacement DSCP.
`timescale 1ns/1ps
`default_nettype none
`include "erw_defs.vh"

module erw_top (
    input wire clk,
    input wire rst_b,
    input wire [`ERW_AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`ERW_AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire desc_valid,
    input wire [4:0] desc_egr_port,
    input wire [4:0] desc_igr_port,
    input wire [11:0] desc_vid,
    input wire [2:0] desc_qos_class,
    input wire [2:0] desc_pcp,
    input wire desc_dei,
    input wire [5:0] desc_dscp,
    input wire desc_is_ip,
    input wire desc_ctag_in,
    input wire desc_from_cpu,
    input wire fr_valid,
    input wire fr_first,
    input wire fr_last,
    input wire [7:0] fr_data,
    output reg dec_valid,
    output reg dec_discard,
    output reg dec_age_disable,
    output reg dec_tag_insert,
    output reg [15:0] dec_tpid,
    output reg [2:0] dec_pcp,
    output reg dec_dei,
    output reg [11:0] dec_vid,
    output reg dec_hdr_insert,
    output reg dec_hdr_position,
    output reg [2:0] dec_qos_class,
    output reg [5:0] dec_dscp,
    output reg dec_changed,
    output reg dec_crc_recompute,
    output wire [31:0] fcs_value,
    output wire fcs_valid,
    output reg fcs_replace
);

    // Configuration storage, one flip-flop set per port or table entry
    reg [31:0] port_vlan_tag_values [0:27];
    reg [6:0] port_tagging_control [0:27];
    reg [7:1] port_special_control [0:27];
    reg [1:0] port_dscp_rewrite_mode [0:27];
    reg [1:0] port_ingress_qos [0:27];
    reg [3:0] class_to_pcp_dei_map [0:`ERW_NMAP-1];
    reg [5:0] shared_codepoint_remap [0:63];
    reg [10:0] dscp_classification_entry [0:63];
    reg [5:0] class_to_dscp_entry [0:7];

    wire wr_en;
    wire [`ERW_AW-1:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire [`ERW_AW-1:0] rd_addr;
    wire [32:0] rd_word;
    wire [32:0] wr_old;
    reg [31:0] wr_mask;
    reg [31:0] wr_merged;
    reg crc_policy;
    integer k;

    erw_axil u_axil (
        .clk(clk),
        .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_hit(wr_old[32]),
        .rd_addr(rd_addr),
        .rd_data(rd_word[31:0]),
        .rd_hit(rd_word[32])
    );

    // Decode and read-back, {hit, data}; per-port groups below the common base
    function [32:0] erw_read;
        input [`ERW_AW-1:0] a;
        reg [4:0] p;
        reg [6:0] o;
        reg [6:0] m;
        begin
            p = a[`ERW_PORT_IDX];
            o = {a[6:2], 2'b00};
            m = o - `ERW_OFF_MAP;
            erw_read = 33'h000000000;
            if (a < `ERW_COMMON_BASE) begin
                if (p < `ERW_NPORTS) begin
                    if (o == `ERW_OFF_VLAN)
                        erw_read = {1'b1, port_vlan_tag_values[p]};
                    else if (o == `ERW_OFF_TAG)
                        erw_read = {1'b1, 25'h0000000, port_tagging_control[p]};
                    else if (o == `ERW_OFF_SPEC)
                        erw_read = {1'b1, 24'h000000, port_special_control[p], 1'b0};
                    else if (o == `ERW_OFF_DSCP)
                        erw_read = {1'b1, 30'h00000000, port_dscp_rewrite_mode[p]};
                    else if (o >= `ERW_OFF_MAP && o < `ERW_OFF_IGRQ)
                        erw_read = {1'b1, 28'h0000000, class_to_pcp_dei_map[{p, m[4:2]}]};
                    else if (o == `ERW_OFF_IGRQ)
                        erw_read = {1'b1, 30'h00000000, port_ingress_qos[p]};
                end
            end else if (a[12:8] == `ERW_REMAP_PAGE) begin
                erw_read = {1'b1, 26'h0000000, shared_codepoint_remap[a[7:2]]};
            end else if (a[12:8] == `ERW_CLS_PAGE) begin
                erw_read = {1'b1, 21'h000000, dscp_classification_entry[a[7:2]]};
            end else if (a[12:5] == `ERW_C2D_PAGE) begin
                erw_read = {1'b1, 26'h0000000, class_to_dscp_entry[a[4:2]]};
            end
        end
    endfunction

    assign rd_word = erw_read(rd_addr);
    assign wr_old = erw_read(wr_addr);

    // Byte enables merge new lanes over the stored value
    always @* begin
        wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
        wr_merged = (wr_old[31:0] & ~wr_mask) | (wr_data & wr_mask);
    end

    // Register writes; unmapped writes are answered with an error and dropped
    always @(posedge clk) begin
        if (!rst_b) begin
            for (k = 0; k < 28; k = k + 1) begin
                port_vlan_tag_values[k] <= `ERW_RST_VLAN;
                port_tagging_control[k] <= 7'h00;
                port_special_control[k] <= `ERW_RST_SPEC;
                port_dscp_rewrite_mode[k] <= 2'h0;
                port_ingress_qos[k] <= 2'h0;
            end
            for (k = 0; k < `ERW_NMAP; k = k + 1)
                class_to_pcp_dei_map[k] <= 4'h0;
            for (k = 0; k < 64; k = k + 1) begin
                shared_codepoint_remap[k] <= 6'h00;
                dscp_classification_entry[k] <= 11'h000;
            end
            for (k = 0; k < 8; k = k + 1)
                class_to_dscp_entry[k] <= 6'h00;
        end else if (wr_en && wr_old[32]) begin
            if (wr_addr < `ERW_COMMON_BASE) begin
                case ({wr_addr[6:2], 2'b00})
                    `ERW_OFF_VLAN: port_vlan_tag_values[wr_addr[`ERW_PORT_IDX]] <= wr_merged;
                    `ERW_OFF_TAG: port_tagging_control[wr_addr[`ERW_PORT_IDX]] <=
                        {wr_merged[6:3], 1'b0, wr_merged[1:0]};
                    `ERW_OFF_SPEC: port_special_control[wr_addr[`ERW_PORT_IDX]] <=
                        wr_merged[7:1];
                    `ERW_OFF_DSCP: port_dscp_rewrite_mode[wr_addr[`ERW_PORT_IDX]] <=
                        wr_merged[1:0];
                    `ERW_OFF_IGRQ: port_ingress_qos[wr_addr[`ERW_PORT_IDX]] <=
                        wr_merged[1:0];
                    default: class_to_pcp_dei_map[{wr_addr[`ERW_PORT_IDX],
                        wr_addr[4:2] - 3'h4}] <= wr_merged[3:0];
                endcase
            end else if (wr_addr[12:8] == `ERW_REMAP_PAGE) begin
                shared_codepoint_remap[wr_addr[7:2]] <= wr_merged[5:0];
            end else if (wr_addr[12:8] == `ERW_CLS_PAGE) begin
                dscp_classification_entry[wr_addr[7:2]] <= wr_merged[10:0];
            end else begin
                class_to_dscp_entry[wr_addr[4:2]] <= wr_merged[5:0];
            end
        end
    end

    // Per-frame decision, combinational ahead of the output register
    reg [4:0] ep;
    reg [4:0] ip;
    reg port_bad;
    reg [31:0] vcfg;
    reg [6:0] tcfg;
    reg [7:1] scfg;
    reg [5:0] trans_dscp;
    reg [2:0] cls;
    reg [5:0] ana_dscp;
    reg [5:0] next_dscp;
    reg [3:0] map_ent;
    reg next_tag;
    reg [15:0] next_tpid;
    reg [2:0] next_pcp;
    reg next_dei;
    reg next_changed;
    reg next_crc;

    always @* begin
        port_bad = (desc_egr_port >= `ERW_NPORTS) || (desc_igr_port >= `ERW_NPORTS);
        // Out-of-range ports fall back to port 0 tables and the frame is dropped
        ep = (desc_egr_port < `ERW_NPORTS) ? desc_egr_port : 5'h00;
        ip = (desc_igr_port < `ERW_NPORTS) ? desc_igr_port : 5'h00;
        vcfg = port_vlan_tag_values[ep];
        tcfg = port_tagging_control[ep];
        scfg = port_special_control[ep];

        // Ingress translation and trusted codepoint classification
        if (port_ingress_qos[ip][1])
            trans_dscp = dscp_classification_entry[desc_dscp][`ERW_F_XLAT];
        else
            trans_dscp = desc_dscp;
        if (port_ingress_qos[ip][0] && dscp_classification_entry[desc_dscp][`ERW_F_TRUST])
            cls = dscp_classification_entry[desc_dscp][`ERW_F_CLS];
        else
            cls = desc_qos_class;

        // Rewritable codepoints take the class value
        if (dscp_classification_entry[trans_dscp][`ERW_F_RWSEL])
            ana_dscp = class_to_dscp_entry[cls];
        else
            ana_dscp = trans_dscp;

        // Egress codepoint rewrite; mode 3 is left as no update
        case (port_dscp_rewrite_mode[ep])
            2'h1: next_dscp = ana_dscp;
            2'h2: next_dscp = shared_codepoint_remap[ana_dscp];
            default: next_dscp = trans_dscp;
        endcase
        if (!desc_is_ip)
            next_dscp = desc_dscp;

        // Port tag insertion
        case (tcfg[`ERW_F_TAGMODE])
            2'h1: next_tag = (desc_vid != 12'h000) && (desc_vid != vcfg[`ERW_F_PVID]);
            2'h2: next_tag = (desc_vid != 12'h000);
            2'h3: next_tag = 1'b1;
            default: next_tag = 1'b0;
        endcase

        // Ethertype of the added tag
        case (tcfg[`ERW_F_TPIDSEL])
            2'h0: next_tpid = `ERW_TPID_C;
            2'h1: next_tpid = `ERW_TPID_S;
            2'h2: next_tpid = vcfg[`ERW_F_TPID];
            default: next_tpid = desc_ctag_in ? `ERW_TPID_C : vcfg[`ERW_F_TPID];
        endcase

        // Priority and drop eligibility; reserved source acts as classified
        map_ent = class_to_pcp_dei_map[{ep, cls}];
        case (tcfg[`ERW_F_QOSSRC])
            2'h2: begin
                next_pcp = vcfg[`ERW_F_PPCP];
                next_dei = vcfg[`ERW_F_PDEI];
            end
            2'h3: begin
                next_pcp = map_ent[`ERW_F_MPCP];
                next_dei = map_ent[`ERW_F_MDEI];
            end
            default: begin
                next_pcp = desc_pcp;
                next_dei = desc_dei;
            end
        endcase

        // Content change and checksum policy
        next_changed = next_tag || scfg[`ERW_F_HDREN] || (next_dscp != desc_dscp);
        if (desc_from_cpu)
            next_crc = scfg[`ERW_F_CRCCPU];
        else if (scfg[`ERW_F_CRCNET] == 2'h0)
            next_crc = next_changed;
        else
            next_crc = (scfg[`ERW_F_CRCNET] == 2'h2);
    end

    // Decision register, one cycle after the descriptor
    always @(posedge clk) begin
        if (!rst_b) begin
            dec_valid <= 1'b0;
            dec_discard <= 1'b0;
            dec_age_disable <= 1'b0;
            dec_tag_insert <= 1'b0;
            dec_tpid <= 16'h0000;
            dec_pcp <= 3'h0;
            dec_dei <= 1'b0;
            dec_vid <= 12'h000;
            dec_hdr_insert <= 1'b0;
            dec_hdr_position <= 1'b0;
            dec_qos_class <= 3'h0;
            dec_dscp <= 6'h00;
            dec_changed <= 1'b0;
            dec_crc_recompute <= 1'b0;
            crc_policy <= 1'b0;
        end else begin
            dec_valid <= desc_valid;
            if (desc_valid) begin
                dec_discard <= scfg[`ERW_F_FLUSH] || port_bad;
                dec_age_disable <= scfg[`ERW_F_AGEDIS];
                dec_tag_insert <= next_tag;
                dec_tpid <= next_tpid;
                dec_pcp <= next_pcp;
                dec_dei <= next_dei;
                dec_vid <= desc_vid;
                dec_hdr_insert <= scfg[`ERW_F_HDREN];
                dec_hdr_position <= scfg[`ERW_F_HDRPOS];
                dec_qos_class <= cls;
                dec_dscp <= next_dscp;
                dec_changed <= next_changed;
                dec_crc_recompute <= next_crc;
                crc_policy <= next_crc;
            end
        end
    end

    // Checksum over the modified frame bytes; policy of the latest decision
    erw_crc32 u_crc (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(fr_valid),
        .in_first(fr_first),
        .in_last(fr_last),
        .in_data(fr_data),
        .fcs(fcs_value),
        .fcs_valid(fcs_valid)
    );

    // Whether the MAC should replace the trailer with the new value
    always @(posedge clk) begin
        if (!rst_b)
            fcs_replace <= 1'b0;
        else if (fr_valid && fr_last)
            fcs_replace <= crc_policy;
    end

endmodule
`default_nettype wire

/* File: erw_defs.vh */
`ifndef ERW_DEFS_VH
`define ERW_DEFS_VH

// Bus geometry
`define ERW_AW 13
`define ERW_NPORTS 5'h1C
`define ERW_NMAP 224

// Per-port group offsets; group index sits at address bits 11:7 (0x80 apart)
`define ERW_PORT_IDX 11:7
`define ERW_PORT_OFF 6:0
`define ERW_OFF_VLAN 7'h00
`define ERW_OFF_TAG 7'h04
`define ERW_OFF_SPEC 7'h08
`define ERW_OFF_DSCP 7'h0C
`define ERW_OFF_MAP 7'h10
`define ERW_OFF_IGRQ 7'h30

// Common group and analyzer tables, selected by address bits 12:8 / 12:5
`define ERW_COMMON_BASE 13'h0E00
`define ERW_REMAP_PAGE 5'h0F
`define ERW_CLS_PAGE 5'h10
`define ERW_C2D_PAGE 8'h88

// Port tag values fields
`define ERW_F_TPID 31:16
`define ERW_F_PDEI 15
`define ERW_F_PPCP 14:12
`define ERW_F_PVID 11:0
`define ERW_RST_VLAN 32'h00000001

// Tagging control fields
`define ERW_F_TAGMODE 6:5
`define ERW_F_TPIDSEL 4:3
`define ERW_F_QOSSRC 1:0

// Special control fields
`define ERW_F_HDREN 7
`define ERW_F_HDRPOS 6
`define ERW_F_CRCNET 5:4
`define ERW_F_CRCCPU 3
`define ERW_F_FLUSH 2
`define ERW_F_AGEDIS 1
`define ERW_RST_SPEC 7'h04

// Class map entry fields
`define ERW_F_MDEI 3
`define ERW_F_MPCP 2:0

// Analyzer codepoint entry fields
`define ERW_F_CLS 10:8
`define ERW_F_XLAT 7:2
`define ERW_F_TRUST 1
`define ERW_F_RWSEL 0

// Ethertypes
`define ERW_TPID_C 16'h8100
`define ERW_TPID_S 16'h88A8

// Bus responses and CRC
`define ERW_RESP_OK 2'h0
`define ERW_RESP_ERR 2'h2
`define ERW_CRC_INIT 32'hFFFFFFFF
`define ERW_CRC_POLY 32'hEDB88320

`endif

/* File: erw_axil.v */
`timescale 1ns/1ps
`default_nettype none
`include "erw_defs.vh"

module erw_axil (
    input wire clk,
    input wire rst_b,
    input wire [`ERW_AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`ERW_AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output wire wr_en,
    output reg [`ERW_AW-1:0] wr_addr,
    output reg [31:0] wr_data,
    output reg [3:0] wr_strb,
    input wire wr_hit,
    output wire [`ERW_AW-1:0] rd_addr,
    input wire [31:0] rd_data,
    input wire rd_hit
);

    // Address and data may arrive in either order; commit once both are held
    assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign rd_addr = s_axi_araddr;

    // Write channels
    always @(posedge clk) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ERW_RESP_OK;
            wr_addr <= {`ERW_AW{1'b0}};
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else begin
            if (s_axi_awready && s_axi_awvalid) begin
                s_axi_awready <= 1'b0;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                s_axi_wready <= 1'b0;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_en) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `ERW_RESP_OK : `ERW_RESP_ERR;
            end
            // Reopen both channels only after the response is taken
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel, data captured on the address handshake
    always @(posedge clk) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ERW_RESP_OK;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_hit ? `ERW_RESP_OK : `ERW_RESP_ERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule
`default_nettype wire

/* File: erw_crc32.v */
`timescale 1ns/1ps
`default_nettype none
`include "erw_defs.vh"

module erw_crc32 (
    input wire clk,
    input wire rst_b,
    input wire in_valid,
    input wire in_first,
    input wire in_last,
    input wire [7:0] in_data,
    output reg [31:0] fcs,
    output reg fcs_valid
);

    reg [31:0] crc;
    reg [31:0] next_crc;
    integer i;

    // Reflected CRC-32, one byte per cycle, bit 0 of each byte first
    always @* begin
        next_crc = in_first ? `ERW_CRC_INIT : crc;
        for (i = 0; i < 8; i = i + 1) begin
            if (next_crc[0] ^ in_data[i])
                next_crc = (next_crc >> 1) ^ `ERW_CRC_POLY;
            else
                next_crc = next_crc >> 1;
        end
    end

    // Running state; finished value is inverted, low byte sent first
    always @(posedge clk) begin
        if (!rst_b) begin
            crc <= `ERW_CRC_INIT;
            fcs <= 32'h00000000;
            fcs_valid <= 1'b0;
        end else begin
            fcs_valid <= 1'b0;
            if (in_valid) begin
                crc <= next_crc;
                if (in_last) begin
                    fcs <= ~next_crc;
                    fcs_valid <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* File: erw_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module erw_top_sva (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic desc_valid,
    input wire logic [4:0] desc_egr_port,
    input wire logic desc_is_ip,
    input wire logic [5:0] desc_dscp,
    input wire logic dec_valid,
    input wire logic dec_discard,
    input wire logic dec_tag_insert,
    input wire logic dec_hdr_insert,
    input wire logic dec_changed,
    input wire logic [5:0] dec_dscp,
    input wire logic fr_valid,
    input wire logic fr_last,
    input wire logic fcs_valid,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
// Write steps: both halves taken, then one response
sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence b_done;
    s_axi_bvalid && s_axi_bready;
endsequence
wr_resp_a: assert property (wr_take |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
b_once_a: assert property (b_done |=> !s_axi_bvalid)
    else $error("write response repeated");
dec_pulse_a: assert property (desc_valid |=> dec_valid)
    else $error("decision missing");
dec_cause_a: assert property (dec_valid |-> $past(desc_valid))
    else $error("decision without descriptor");
bad_port_a: assert property (desc_valid && desc_egr_port > 5'd27 |=> dec_discard)
    else $error("port out of range kept");
non_ip_a: assert property (desc_valid && !desc_is_ip |=> dec_dscp == $past(desc_dscp))
    else $error("non ip codepoint changed");
edit_flag_a: assert property (dec_valid && (dec_tag_insert || dec_hdr_insert)
    |-> dec_changed)
    else $error("edit not flagged");
fcs_time_a: assert property (fr_valid && fr_last |=> fcs_valid)
    else $error("checksum late");
fcs_cause_a: assert property (fcs_valid |-> $past(fr_valid) && $past(fr_last))
    else $error("checksum without frame end");
endmodule
bind erw_top erw_top_sva u_sva (.*);
`default_nettype wire

/* File: erw_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Queue side: streams a nine byte frame per go pulse
module erw_far_model (
    input wire logic clk,
    input wire logic go,
    output logic fr_valid,
    output logic fr_first,
    output logic fr_last,
    output logic [7:0] fr_data
);
int n = -1;
// Byte counter, idle at -1; bytes back to back, one every clock
always @(posedge clk) begin
    n <= (n >= 0) ? ((n == 8) ? -1 : n + 1) : (go ? 0 : -1);
end
assign fr_valid = n >= 0;
assign fr_first = n == 0;
assign fr_last = n == 8;
// Idle data inverts the last byte so stale data never looks valid
assign fr_data = fr_valid ? 8'h31 + n[7:0] : 8'hC6;
endmodule
`default_nettype wire

/* File: tb_egress_frame_rewriter.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_egress_frame_rewriter;
logic clk = 0, rst_b = 0, go = 0, desc_valid = 0, desc_dei = 0, desc_is_ip = 1;
logic desc_ctag_in = 0, desc_from_cpu = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
logic [12:0] s_axi_awaddr = 0, s_axi_araddr = 0;
logic [31:0] s_axi_wdata = 0, d;
logic [3:0] s_axi_wstrb = 4'hF;
logic [4:0] desc_egr_port = 2, desc_igr_port = 4;
logic [11:0] desc_vid = 0;
logic [2:0] desc_qos_class = 0, desc_pcp = 1;
logic [5:0] desc_dscp = 10;
logic [1:0] r;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata, fcs_value;
wire dec_valid, dec_discard, dec_age_disable, dec_tag_insert, dec_dei, dec_hdr_insert;
wire dec_hdr_position, dec_changed, dec_crc_recompute, fcs_valid, fcs_replace;
wire fr_valid, fr_first, fr_last;
wire [15:0] dec_tpid;
wire [2:0] dec_pcp, dec_qos_class;
wire [11:0] dec_vid;
wire [5:0] dec_dscp;
wire [7:0] fr_data;
int num_errors = 0, tests_run = 0, cyc = 0, m, j, s, k;
logic [7:0] sp [0:6] = '{8'h00, 8'h80, 8'h90, 8'h20, 8'h08, 8'h80, 8'h30};
erw_top u_dut (.*);
erw_far_model u_far (.*);
initial forever #20 clk = ~clk;
// Hang guard, far above the test length
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
        num_errors++;
        stop_test;
    end
end
task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
        num_errors++;
        $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
endtask
// Write: address and data offered together, each dropped once taken
task wr(input logic [12:0] a, input logic [31:0] v);
    bit ta, tw;
    {ta, tw} = 2'b00;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(ta && tw)) begin
        @(posedge clk);
        if (s_axi_awvalid && s_axi_awready && !ta) begin
            ta = 1;
            s_axi_awvalid <= 0;
        end
        if (s_axi_wvalid && s_axi_wready && !tw) begin
            tw = 1;
            s_axi_wvalid <= 0;
        end
    end
    s_axi_bready <= 1;
    do @(posedge clk); while (!s_axi_bvalid);
    chk(s_axi_bresp, 0, "write resp");
    s_axi_bready <= 0;
endtask
task rd(input logic [12:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
endtask
// One descriptor; its decision is read one edge later, while it stands
task dsc;
    @(posedge clk);
    desc_valid <= 1;
    @(posedge clk);
    desc_valid <= 0;
    @(posedge clk);
endtask
task stop_test;
    $display("tests_run %0d num_errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask
initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1;
    rd(13'h0180);
    chk(d, 32'h1, "vlan reset");
    rd(13'h0188);
    chk(d, 32'h8, "special reset");
    rd(13'h1200);
    chk(r, 2, "unmapped resp");
    $display("test reset done");
    wr(13'h0100, 32'h9100D0AB);
    rd(13'h0100);
    chk(d, 32'h9100D0AB, "vlan rw");
    for (m = 0; m < 4; m++) begin
        wr(13'h0104, m << 5);
        for (j = 0; j < 3; j++) begin
            desc_vid <= (j == 0) ? 12'h000 : (j == 1) ? 12'h0AB : 12'h123;
            dsc;
            chk(dec_tag_insert, m == 3 || (m > 0 && j == 2) || (m == 2 && j == 1), "tag");
        end
    end
    for (s = 0; s < 4; s++) begin
        wr(13'h0104, 32'h60 | (s << 3));
        for (j = 0; j < 2; j++) begin
            desc_ctag_in <= j;
            dsc;
            chk(dec_tpid, (s == 0 || (s == 3 && j == 1)) ? 16'h8100 :
                (s == 1) ? 16'h88A8 : 16'h9100, "tpid");
        end
    end
    $display("test tagging done");
    wr(13'h0128, 32'hA);
    desc_qos_class <= 6;
    for (s = 0; s < 4; s++) begin
        wr(13'h0104, 32'h60 | s);
        dsc;
        chk({dec_pcp, dec_dei}, s < 2 ? 4'h2 : s == 2 ? 4'hB : 4'h5, "priority");
    end
    $display("test priority done");
    // Header insert, header position, flush and ageing together in one write
    wr(13'h0108, 32'hC6);
    dsc;
    chk({dec_hdr_insert, dec_hdr_position, dec_discard, dec_age_disable}, 4'hF,
        "spec");
    wr(13'h0104, 32'h0);
    for (k = 0; k < 7; k++) begin
        wr(13'h0108, sp[k]);
        desc_from_cpu <= k == 4 || k == 5;
        dsc;
        chk(dec_crc_recompute, k == 1 || k == 3 || k == 4, "crc mode");
    end
    wr(13'h0108, 32'h20);
    desc_from_cpu <= 0;
    dsc;
    @(posedge clk);
    go <= 1;
    @(posedge clk);
    go <= 0;
    for (j = 0; j < 30 && fcs_valid !== 1'b1; j++) begin
        @(posedge clk);
        #1;
    end
    chk(fcs_value, 32'hCBF43926, "fcs");
    chk(fcs_replace, 1, "fcs replace");
    $display("test checksum done");
    wr(13'h0108, 32'h0);
    wr(13'h0230, 32'h1);
    wr(13'h1028, 32'h303);
    wr(13'h110C, 32'h15);
    wr(13'h0F54, 32'h2D);
    desc_qos_class <= 0;
    for (m = 0; m < 3; m++) begin
        wr(13'h010C, m);
        dsc;
        chk(dec_dscp, m == 0 ? 6'd10 : m == 1 ? 6'h15 : 6'h2D, "dscp");
        chk(dec_qos_class, 3, "class");
    end
    wr(13'h1028, 32'h301);
    dsc;
    chk(dec_qos_class, 0, "untrusted class");
    desc_is_ip <= 0;
    dsc;
    chk(dec_dscp, 10, "non ip");
    desc_egr_port <= 28;
    dsc;
    chk({dec_valid, dec_discard, dec_vid}, {2'h3, 12'h123}, "bad port");
    $display("test codepoint done");
    stop_test;
end
endmodule
`default_nettype wire
